//--- hw/btcb_regs.svh
/*
  Constants for the bit-test, compare and overflow-branch execution slice:
  opcode prefixes, field positions and addressing limits.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BTCB_REGS_SVH
`define BTCB_REGS_SVH

// opcode prefixes, instr[15:12]
`define BTCB_OP_SKIP_CLR 4'hb
`define BTCB_OP_SKIP_SET 4'ha
`define BTCB_OP_BIT_INV 4'h7
`define BTCB_OP_GRP6 4'h6
`define BTCB_OP_GRP_E 4'he
// sub codes, instr[11:9] in group 6 and instr[11:8] in group e
`define BTCB_SUB_CMP_GT 3'h2
`define BTCB_SUB_CMP_LT 3'h0
`define BTCB_SUB_BOV 4'h4
// field positions
`define BTCB_OP_HI 15
`define BTCB_OP_LO 12
`define BTCB_BIT_HI 11
`define BTCB_BIT_LO 9
`define BTCB_ACC_BIT 8
`define BTCB_F_HI 7
`define BTCB_F_LO 0
// indexed literal offset window upper bound
`define BTCB_IDX_MAX 8'h5f
// program counter step of one word, in bytes
`define BTCB_PC_STEP 21'h000002
// nop cycles owed after a skip or a taken branch
`define BTCB_NOP_ONE 2'h1
`define BTCB_NOP_TWO 2'h2

`endif

//--- hw/btcb_pkg.sv
/*
  Types shared by the execution slice: the decoded operation, the four
  phase enum and the data-memory request carrier.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package btcb_pkg;

  typedef enum logic [2:0] {
    BTCB_NONE,
    BTCB_SKIP_CLR,
    BTCB_SKIP_SET,
    BTCB_BIT_INV,
    BTCB_BOV,
    BTCB_CMP_GT,
    BTCB_CMP_LT
  } btcb_op_t;

  typedef enum logic [1:0] {
    BTCB_PH_Q1,
    BTCB_PH_Q2,
    BTCB_PH_Q3,
    BTCB_PH_Q4
  } btcb_phase_t;

  typedef struct packed {
    logic [11:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } btcb_mem_req_t;

endpackage : btcb_pkg

//--- hw/btcb_decode.sv
/*
  Combinational decoder for one program word of the execution slice.
  Assumes the word is stable during the whole instruction cycle.
*/
`timescale 1ns/10ps
`include "btcb_regs.svh"

module btcb_decode (
  // instruction word
  input wire logic [15:0] instr,
  // decoded fields
  output btcb_pkg::btcb_op_t op,
  output logic [2:0] bit_idx,
  output logic acc,
  output logic [7:0] faddr
);

  logic [3:0] pre;

  assign pre = instr[`BTCB_OP_HI:`BTCB_OP_LO];
  assign bit_idx = instr[`BTCB_BIT_HI:`BTCB_BIT_LO];
  assign acc = instr[`BTCB_ACC_BIT];
  assign faddr = instr[`BTCB_F_HI:`BTCB_F_LO];

  always_comb
  begin
    op = btcb_pkg::BTCB_NONE;
    case (pre)
      `BTCB_OP_SKIP_CLR: op = btcb_pkg::BTCB_SKIP_CLR;
      `BTCB_OP_SKIP_SET: op = btcb_pkg::BTCB_SKIP_SET;
      `BTCB_OP_BIT_INV: op = btcb_pkg::BTCB_BIT_INV;
      `BTCB_OP_GRP6:
      begin
        if (instr[`BTCB_BIT_HI:`BTCB_BIT_LO] == `BTCB_SUB_CMP_GT)
          op = btcb_pkg::BTCB_CMP_GT;
        else if (instr[`BTCB_BIT_HI:`BTCB_BIT_LO] == `BTCB_SUB_CMP_LT)
          op = btcb_pkg::BTCB_CMP_LT;
      end
      `BTCB_OP_GRP_E:
      begin
        if (instr[`BTCB_BIT_HI:`BTCB_ACC_BIT] == `BTCB_SUB_BOV)
          op = btcb_pkg::BTCB_BOV;
      end
      default: op = btcb_pkg::BTCB_NONE;
    endcase
  end

endmodule : btcb_decode

//--- hw/btcb_exec.sv
/*
  Execution slice for bit test/skip, bit invert, overflow branch and
  unsigned compare/skip, stepping four phases per instruction cycle.
  Assumes a fetch unit that presents instr at phase Q1 with instr_valid,
  signals next_two_word for the prefetched word, and a data memory that
  returns mem_rdata combinationally by the phase after a read request.
*/
//
// Contract
// - skip-if-clear, prefix 1011, skips next word when the bit reads zero
// - skip-if-set, prefix 1010, skips next word when the bit reads one
// - on skip, the prefetched word is discarded and one nop cycle runs
// - skipping a two-word instruction costs two nop cycles, three total
// - access bit zero picks access bank, one uses bank select register
// - access zero, extended set on, address up to 5fh: indexed offset
// - bit invert, prefix 0111, flips the bit and writes it back
// - branch on overflow, 1110 0100 plus signed offset, only if flag set
// - taken branch target is branch address plus two plus twice offset
// - taken branch two cycles, not taken one cycle advancing the counter
// - compare greater, 0110 010a, unsigned, skips when file above working
// - compare less, 0110 000a, unsigned, skips when file below working
`timescale 1ns/10ps
`include "btcb_regs.svh"

module btcb_exec (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // instruction stream
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic next_two_word,
  input wire logic [20:0] pc_in,
  // core state
  input wire logic [7:0] working_reg,
  input wire logic [3:0] bank_select_reg,
  input wire logic [11:0] fsr2,
  input wire logic ovf_flag,
  input wire logic ext_set_en,
  // data memory
  input wire logic [7:0] mem_rdata,
  output btcb_pkg::btcb_mem_req_t mem_req,
  // program flow
  output logic [20:0] pc_out,
  output logic pc_load,
  output logic flush,
  output logic busy,
  output btcb_pkg::btcb_phase_t phase
);

  btcb_pkg::btcb_op_t dec_op;
  logic [2:0] dec_bit;
  logic dec_acc;
  logic [7:0] dec_f;

  btcb_decode u_dec (
    .instr(instr),
    .op(dec_op),
    .bit_idx(dec_bit),
    .acc(dec_acc),
    .faddr(dec_f)
  );

  btcb_pkg::btcb_phase_t ph_q;
  btcb_pkg::btcb_op_t op_q;
  logic [2:0] bit_q;
  logic [11:0] ea_q;
  logic [11:0] ea_d;
  logic [7:0] off_q;
  logic [20:0] pc_q;
  logic [7:0] data_q;
  logic [7:0] opnd;
  logic [1:0] nop_q;
  logic [1:0] nop_d;
  logic busy_q;
  logic two_q;
  logic cond;
  btcb_pkg::btcb_mem_req_t req_q;
  logic [20:0] pcout_q;
  logic pcld_q;
  logic flush_q;

  // phase counter runs free so the nop cycles keep the same cadence
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      ph_q <= btcb_pkg::BTCB_PH_Q1;
    else
    begin
      case (ph_q)
        btcb_pkg::BTCB_PH_Q1: ph_q <= btcb_pkg::BTCB_PH_Q2;
        btcb_pkg::BTCB_PH_Q2: ph_q <= btcb_pkg::BTCB_PH_Q3;
        btcb_pkg::BTCB_PH_Q3: ph_q <= btcb_pkg::BTCB_PH_Q4;
        btcb_pkg::BTCB_PH_Q4: ph_q <= btcb_pkg::BTCB_PH_Q1;
        default: ph_q <= btcb_pkg::BTCB_PH_Q1;
      endcase
    end
  end

  // effective address of the file operand
  always_comb
  begin
    ea_d = {bank_select_reg, dec_f};
    if (!dec_acc)
    begin
      if (ext_set_en && dec_f <= `BTCB_IDX_MAX)
        ea_d = 12'(fsr2 + {4'h0, dec_f});
      else if (dec_f <= `BTCB_IDX_MAX)
        ea_d = {4'h0, dec_f};
      else
        ea_d = {4'hf, dec_f};
    end
  end

  // q1 decode; a new word is accepted only when no nop cycle is pending
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      op_q <= btcb_pkg::BTCB_NONE;
      bit_q <= 3'h0;
      ea_q <= 12'h000;
      off_q <= 8'h00;
      pc_q <= 21'h000000;
      two_q <= 1'b0;
    end
    else if (ph_q == btcb_pkg::BTCB_PH_Q1)
    begin
      if (instr_valid && nop_q == 2'h0)
        op_q <= dec_op;
      else
        op_q <= btcb_pkg::BTCB_NONE;
      bit_q <= dec_bit;
      ea_q <= ea_d;
      off_q <= dec_f;
      pc_q <= pc_in;
      two_q <= next_two_word;
    end
  end

  // q2 read; the branch reads its literal, not memory
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      data_q <= 8'h00;
    else if (ph_q == btcb_pkg::BTCB_PH_Q3)
      data_q <= mem_rdata;
  end

  // in q3 the operand is still on the memory bus; data_q holds it only from q4
  assign opnd = (ph_q == btcb_pkg::BTCB_PH_Q3) ? mem_rdata : data_q;

  // q3 process: decide skip or branch
  always_comb
  begin
    cond = 1'b0;
    case (op_q)
      btcb_pkg::BTCB_SKIP_CLR: cond = ~opnd[bit_q];
      btcb_pkg::BTCB_SKIP_SET: cond = opnd[bit_q];
      btcb_pkg::BTCB_CMP_GT: cond = opnd > working_reg;
      btcb_pkg::BTCB_CMP_LT: cond = opnd < working_reg;
      btcb_pkg::BTCB_BOV: cond = ovf_flag;
      default: cond = 1'b0;
    endcase
  end

  // nop cycles pending after a skip or taken branch
  always_comb
  begin
    nop_d = nop_q;
    if (ph_q == btcb_pkg::BTCB_PH_Q4)
    begin
      if (cond && op_q == btcb_pkg::BTCB_BOV)
        nop_d = `BTCB_NOP_ONE;
      else if (cond && op_q != btcb_pkg::BTCB_BIT_INV && op_q != btcb_pkg::BTCB_NONE)
        nop_d = two_q ? `BTCB_NOP_TWO : `BTCB_NOP_ONE;
      else if (nop_q != 2'h0)
        nop_d = nop_q - `BTCB_NOP_ONE;
    end
  end

  // busy comes from the next count so the output is a plain flop
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      nop_q <= 2'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      nop_q <= nop_d;
      busy_q <= nop_d != 2'h0;
    end
  end

  // memory port: read in q2, write back in q4 only for bit invert
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      req_q <= '0;
    else
    begin
      // the read leaves in q2, before ea_q has caught up with the new word
      req_q.addr <= (ph_q == btcb_pkg::BTCB_PH_Q1) ? ea_d : ea_q;
      req_q.rd <= ph_q == btcb_pkg::BTCB_PH_Q1 && instr_valid && nop_q == 2'h0
                  && dec_op != btcb_pkg::BTCB_BOV && dec_op != btcb_pkg::BTCB_NONE;
      // compares and tests never write, so operands stay intact
      req_q.wr <= ph_q == btcb_pkg::BTCB_PH_Q3 && op_q == btcb_pkg::BTCB_BIT_INV;
      req_q.wdata <= opnd ^ (8'h01 << bit_q);
    end
  end

  // program counter write on a taken branch, in q4
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pcout_q <= 21'h000000;
      pcld_q <= 1'b0;
    end
    else
    begin
      pcld_q <= ph_q == btcb_pkg::BTCB_PH_Q3 && op_q == btcb_pkg::BTCB_BOV && cond;
      // offset sign-extended and doubled; wraps in the 21-bit space
      pcout_q <= 21'(pc_q + `BTCB_PC_STEP + {{12{off_q[7]}}, off_q, 1'b0});
    end
  end

  // discard of the prefetched word is signalled through the last q4
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      flush_q <= 1'b0;
    else
      flush_q <= ph_q == btcb_pkg::BTCB_PH_Q3 && cond;
  end

  assign mem_req = req_q;
  assign pc_out = pcout_q;
  assign pc_load = pcld_q;
  assign flush = flush_q;
  assign busy = busy_q;
  assign phase = ph_q;

endmodule : btcb_exec

//--- testbench/btcb_exec_chk.sv
/*
  Port checker for btcb_exec: phase ring, pulse placement, nop cycles
  and branch target. Assumes a bind onto btcb_exec and instr held steady.
*/
`timescale 1ns/10ps
module btcb_exec_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // watched ports
  input wire logic [15:0] instr,
  input wire logic [20:0] pc_in,
  input btcb_pkg::btcb_mem_req_t mem_req,
  input wire logic [20:0] pc_out,
  input wire logic pc_load,
  input wire logic flush,
  input wire logic busy,
  input btcb_pkg::btcb_phase_t phase
);
  wire logic [20:0] tgt = pc_in + 21'h000002 + {{12{instr[7]}}, instr[7:0], 1'b0};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_phase_ring_step: assert property (rst_b |=> phase ==
    btcb_pkg::btcb_phase_t'($past(phase) + 2'h1)) else $error("phase skipped");
  a_read_in_q2: assert property (mem_req.rd |-> phase == btcb_pkg::BTCB_PH_Q2)
    else $error("read outside Q2");
  a_write_in_q4: assert property (mem_req.wr |-> phase == btcb_pkg::BTCB_PH_Q4 && !flush)
    else $error("bad write pulse");
  a_flush_in_q4: assert property (flush |-> phase == btcb_pkg::BTCB_PH_Q4)
    else $error("flush outside Q4");
  a_load_with_flush: assert property (pc_load |-> flush)
    else $error("load without flush");
  a_flush_nop_cycle: assert property (flush |=> busy [*4])
    else $error("nop cycle missing");
  a_read_not_busy: assert property (mem_req.rd |-> !busy)
    else $error("read during nop");
  a_branch_target: assert property (pc_load |-> pc_out == $past(tgt, 3))
    else $error("wrong branch target");
  c_skip: cover property (flush && !pc_load);
  c_branch: cover property (pc_load);
  c_invert: cover property (mem_req.wr);
endmodule : btcb_exec_chk

bind btcb_exec btcb_exec_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .instr(instr),
  .pc_in(pc_in), .mem_req(mem_req), .pc_out(pc_out), .pc_load(pc_load),
  .flush(flush), .busy(busy), .phase(phase));

//--- testbench/bit_test_compare_branch_exec_tb_top.sv
/*
  Directed bench for btcb_exec: skips, bit invert, overflow branch and
  compares. Assumes the checker file is compiled alongside.
*/
`timescale 1ns/10ps
module bit_test_compare_branch_exec_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'b0;
  logic next_two_word = 1'b0;
  logic [20:0] pc_in = 21'h000100;
  logic [7:0] working_reg = 8'h7f;
  logic [3:0] bank_select_reg = 4'h3;
  logic [11:0] fsr2 = 12'h200;
  logic ovf_flag = 1'b0;
  logic ext_set_en = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  btcb_pkg::btcb_mem_req_t mem_req;
  logic [20:0] pc_out;
  logic pc_load;
  logic flush;
  logic busy;
  btcb_pkg::btcb_phase_t phase;
  int failures = 0;
  int checks_done = 0;
  logic s_fl;
  logic s_pl;
  logic s_wr;
  logic [7:0] nops;
  logic [11:0] s_addr;
  logic [7:0] s_wd;
  logic [20:0] s_pc;

  always #5 ref_clk = ~ref_clk;

  btcb_exec dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr(instr), .instr_valid(instr_valid),
    .next_two_word(next_two_word), .pc_in(pc_in), .working_reg(working_reg),
    .bank_select_reg(bank_select_reg), .fsr2(fsr2), .ovf_flag(ovf_flag),
    .ext_set_en(ext_set_en), .mem_rdata(mem_rdata), .mem_req(mem_req), .pc_out(pc_out),
    .pc_load(pc_load), .flush(flush), .busy(busy), .phase(phase));

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // present one word for a whole q1 cycle, then watch 15 cycles from its q2
  task automatic go(input logic [15:0] w, input logic [7:0] rdv, input logic two);
    int i;
    i = 0;
    @(posedge ref_clk);
    #1;
    while (phase !== btcb_pkg::BTCB_PH_Q4 && i < 8)
    begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    if (i == 8)
    begin
      failures++;
      results;
    end
    @(posedge ref_clk);
    instr <= w;
    instr_valid <= 1'b1;
    mem_rdata <= rdv;
    next_two_word <= two;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    {s_fl, s_pl, s_wr, nops} = '0;
    s_addr = 'x;
    s_wd = 'x;
    s_pc = 'x;
    for (i = 0; i < 15; i++)
    begin
      #1;
      s_fl |= flush;
      s_pl |= pc_load;
      if (pc_load === 1'b1)
        s_pc = pc_out;
      if (mem_req.wr === 1'b1)
        s_wd = mem_req.wdata;
      s_wr |= mem_req.wr;
      if (mem_req.rd === 1'b1)
        s_addr = mem_req.addr;
      if (busy === 1'b1)
        nops++;
      @(posedge ref_clk);
    end
  endtask : go

  task automatic want(input logic fl, input logic pl, input logic wr, input logic [7:0] n);
    check(s_fl, fl);
    check(s_pl, pl);
    check(s_wr, wr);
    check(nops, n);
  endtask : want

  task automatic t_skip_bits;
    go(16'hb740, 8'hf7, 1'b0);
    want(1'b1, 1'b0, 1'b0, 8'd4);
    check(s_addr, 12'h340);
    go(16'hb740, 8'h08, 1'b0);
    want(1'b0, 1'b0, 1'b0, 8'd0);
    go(16'hae80, 8'h80, 1'b1);
    want(1'b1, 1'b0, 1'b0, 8'd8);
    check(s_addr, 12'hf80);
    go(16'hae80, 8'h7f, 1'b1);
    want(1'b0, 1'b0, 1'b0, 8'd0);
  endtask : t_skip_bits

  task automatic t_invert;
    ext_set_en <= 1'b1;
    go(16'h7810, 8'h75, 1'b1);
    want(1'b0, 1'b0, 1'b1, 8'd0);
    check(s_wd, 8'h65);
    check(s_addr, 12'h210);
    go(16'h705f, 8'h01, 1'b0);
    check(s_wd, 8'h00);
    check(s_addr, 12'h25f);
    go(16'h7060, 8'h00, 1'b0);
    check(s_addr, 12'hf60);
    ext_set_en <= 1'b0;
  endtask : t_invert

  task automatic t_branch;
    ovf_flag <= 1'b1;
    go(16'he4fe, 8'h00, 1'b0);
    want(1'b1, 1'b1, 1'b0, 8'd4);
    check(s_pc, 21'h0000fe);
    go(16'he47f, 8'h00, 1'b0);
    check(s_pc, 21'h000200);
    ovf_flag <= 1'b0;
    go(16'he47f, 8'h00, 1'b0);
    want(1'b0, 1'b0, 1'b0, 8'd0);
  endtask : t_branch

  task automatic t_compare;
    go(16'h6520, 8'h80, 1'b0);
    want(1'b1, 1'b0, 1'b0, 8'd4);
    go(16'h6420, 8'h7f, 1'b0);
    want(1'b0, 1'b0, 1'b0, 8'd0);
    go(16'h6120, 8'h00, 1'b0);
    want(1'b1, 1'b0, 1'b0, 8'd4);
    go(16'h6020, 8'h80, 1'b0);
    want(1'b0, 1'b0, 1'b0, 8'd0);
  endtask : t_compare

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_skip_bits;
    t_invert;
    t_branch;
    t_compare;
    results;
  end
endmodule : bit_test_compare_branch_exec_tb_top
